// >>> complementary_pwm_deadtime_generator.sv
// How it works
// - Generator control bit 9 cleared follows the shared master time base.
// - Phase change on master time base still keeps full dead time at handover.
// - Output control bits 11:10 select redundant (10) or push-pull (01).
// - Generator control bit 8 picks local or master duty value.
// - With immediate update off, new duty takes effect at period boundary.
// - Redundant or push-pull duty change to zero gives no boundary glitch.
// - With immediate update on, duty changes reach the output at once.
// - Outside complementary mode, an enabled override forces the pin to its programmed override level.
// - Override sync bit 0 cleared applies override changes on clock boundaries.
// - Complementary mode keeps dead time, also when both overrides release.
// - High-side and low-side overrides have separate enable bits.
// - Generator control bit 9 set uses own time base, phase as period.
// - Override enables at bits 9:8, data at bits 7:6.
// - Override sync bit 0 set applies override changes at period boundary.
// - Generator control bit 1, with bit 9 set, lets the current-reset input restart the cycle.
`timescale 1ns/1ps
`include "pwm_gen_consts.svh"

module complementary_pwm_deadtime_generator #(
    parameter int CNT_W = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic pwm_enable_i,
    input wire logic [2:0] pwm_clock_divider_i,
    input wire pwm_gen_pkg::ctrl_word_t generator_control_reg_i,
    input wire pwm_gen_pkg::ctrl_word_t output_control_reg_i,
    input wire logic [CNT_W-1:0] phase_period_reg_i,
    input wire logic [CNT_W-1:0] deadtime_reg_i,
    input wire logic [CNT_W-1:0] local_duty_reg_i,
    input wire logic [CNT_W-1:0] master_duty_i,
    input wire logic [CNT_W-1:0] master_count_i,
    input wire logic master_boundary_i,
    input wire logic current_reset_i,
    output logic high_side_output_o,
    output logic low_side_output_o,
    output logic period_boundary_o
);
    import pwm_gen_pkg::*;

    if (CNT_W < 4 || CNT_W > 32)
    begin : g_bad_width
        $error("CNT_W must lie between 4 and 32");
    end

    // ****************************************
    // Control decode
    // ****************************************
    wire logic imm_upd = generator_control_reg_i[`GEN_IMM_BIT];
    wire logic xrst_mode = generator_control_reg_i[`GEN_XRST_BIT];
    wire logic duty_master = generator_control_reg_i[`GEN_DUTY_SRC_BIT];
    wire logic independent_timebase_sel = generator_control_reg_i[`GEN_ITB_BIT];
    wire logic ovr_sync = output_control_reg_i[`OUT_SYNC_BIT];
    wire logic [1:0] mode_bits = output_control_reg_i[`OUT_MODE_MSB:`OUT_MODE_LSB];
    wire out_mode_e mode = out_mode_e'(mode_bits);
    wire logic current_reset_mode_sel = xrst_mode & independent_timebase_sel;
    wire logic high_override_enable = output_control_reg_i[`OUT_EN_H_BIT];
    wire logic low_override_enable = output_control_reg_i[`OUT_EN_L_BIT];
    wire logic high_ovr_data = output_control_reg_i[`OUT_DATA_H_BIT];
    wire logic low_ovr_data = output_control_reg_i[`OUT_DATA_L_BIT];

    // ****************************************
    // PWM clock divider
    // ****************************************
    logic [`DIV_CNT_W-1:0] div_cnt_ff;
    wire logic [2:0] div_code = (pwm_clock_divider_i > `DIV_MAX_CODE) ? `DIV_MAX_CODE : pwm_clock_divider_i;
    wire logic [`DIV_CNT_W-1:0] div_mask = (`DIV_CNT_W'(1) << div_code) - `DIV_CNT_W'(1);
    wire logic pclk_en = (div_cnt_ff == div_mask);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || pclk_en)
            div_cnt_ff <= `DIV_RST;
        else
            div_cnt_ff <= div_cnt_ff + `DIV_CNT_W'(1);
    end

    // ****************************************
    // Time base
    // ****************************************
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] phase_sh_ff;
    logic [CNT_W-1:0] nxt_cnt;
    wire logic crst_hit = current_reset_mode_sel & current_reset_i;
    wire logic loc_last = (cnt_ff + CNT_W'(1)) >= phase_period_reg_i;
    wire logic loc_bnd = pclk_en & (loc_last | crst_hit);
    wire logic bnd = independent_timebase_sel ? loc_bnd : master_boundary_i;
    // Phase is a fixed offset from the master count, shadowed per period
    wire logic [CNT_W-1:0] master_rel = master_count_i - phase_sh_ff;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (!pwm_enable_i)
            nxt_cnt = '0;
        else if (!independent_timebase_sel)
            nxt_cnt = master_rel;
        else if (loc_bnd)
            nxt_cnt = '0;
        else if (pclk_en)
            nxt_cnt = cnt_ff + CNT_W'(1);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

    // Shadowing keeps a running phase write off the current period on the master time base; the local period compare reads the live register
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            phase_sh_ff <= '0;
        else if (bnd || !pwm_enable_i)
            phase_sh_ff <= phase_period_reg_i;
    end

    // ****************************************
    // Duty selection and update
    // ****************************************
    logic [CNT_W-1:0] duty_ff;
    wire logic [CNT_W-1:0] duty_sel = duty_master ? master_duty_i : local_duty_reg_i;
    wire logic duty_load = imm_upd | bnd | !pwm_enable_i;
    wire logic [CNT_W-1:0] nxt_duty = duty_load ? duty_sel : duty_ff;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            duty_ff <= '0;
        else
            duty_ff <= nxt_duty;
    end

    // Compare uses next count and next duty together, so a duty
    // falling to zero never leaks one stale cycle into the new period
    logic raw_ff;
    logic pp_sel_ff;
    logic bnd_ff;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            raw_ff <= 1'b0;
            pp_sel_ff <= 1'b0;
            bnd_ff <= 1'b0;
        end
        else
        begin
            raw_ff <= pwm_enable_i & (nxt_cnt < nxt_duty);
            bnd_ff <= pwm_enable_i & bnd;
            if (!pwm_enable_i)
                pp_sel_ff <= 1'b0;
            else if (bnd)
                pp_sel_ff <= ~pp_sel_ff;
        end
    end

    // ****************************************
    // Output steering
    // ****************************************
    wire logic is_comp = (mode == MODE_COMP);
    wire logic is_push = (mode == MODE_PUSH);
    wire logic pwm_h = is_comp ? raw_ff : (is_push ? (raw_ff & ~pp_sel_ff) : raw_ff);
    wire logic pwm_l = is_comp ? ~raw_ff & pwm_enable_i : (is_push ? (raw_ff & pp_sel_ff) : raw_ff);

    // ****************************************
    // Override path
    // ****************************************
    logic ovr_en_h_ff;
    logic ovr_en_l_ff;
    logic ovr_dat_h_ff;
    logic ovr_dat_l_ff;
    wire logic ovr_take = ~ovr_sync | bnd;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            ovr_en_h_ff <= 1'b0;
            ovr_en_l_ff <= 1'b0;
            ovr_dat_h_ff <= 1'b0;
            ovr_dat_l_ff <= 1'b0;
        end
        else if (ovr_take)
        begin
            ovr_en_h_ff <= high_override_enable;
            ovr_en_l_ff <= low_override_enable;
            ovr_dat_h_ff <= high_ovr_data;
            ovr_dat_l_ff <= low_ovr_data;
        end
    end

    wire logic h_req = ovr_en_h_ff ? ovr_dat_h_ff : pwm_h;
    wire logic l_req = ovr_en_l_ff ? ovr_dat_l_ff : pwm_l;

    // ****************************************
    // Dead time
    // ****************************************
    // Gating sits after the override mux, so releasing overrides at any
    // instant still passes through the same off-time check
    logic h_ff;
    logic l_ff;
    logic [CNT_W-1:0] off_cnt_ff;
    wire logic dt_ok = (off_cnt_ff >= deadtime_reg_i);
    wire logic h_go = h_req & (h_ff | (~l_ff & dt_ok));
    wire logic l_go = l_req & ~h_go & (l_ff | (~h_ff & dt_ok));
    wire logic nxt_h = is_comp ? h_go : h_req;
    wire logic nxt_l = is_comp ? l_go : l_req;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            h_ff <= `PIN_RST;
            l_ff <= `PIN_RST;
        end
        else
        begin
            h_ff <= nxt_h;
            l_ff <= nxt_l;
        end
    end

    // Counts PWM clocks with both switches off; saturates
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || h_ff || l_ff)
            off_cnt_ff <= '0;
        else if (pclk_en && !(&off_cnt_ff))
            off_cnt_ff <= off_cnt_ff + CNT_W'(1);
    end

    assign high_side_output_o = h_ff;
    assign low_side_output_o = l_ff;
    assign period_boundary_o = bnd_ff;

    // ****************************************
    // Checks
    // ****************************************
    a_no_overlap: assert property (@(posedge core_clk_i) disable iff (rst_i)
        is_comp && $past(is_comp) |-> !(h_ff && l_ff))
        else $error("both outputs high in complementary mode");

    a_high_dead_gap: assert property (@(posedge core_clk_i) disable iff (rst_i)
        is_comp && $rose(h_ff) |-> $past(!l_ff) && $past(off_cnt_ff >= deadtime_reg_i))
        else $error("high side rose without dead time");

    a_low_dead_gap: assert property (@(posedge core_clk_i) disable iff (rst_i)
        is_comp && $rose(l_ff) |-> $past(!h_ff) && $past(off_cnt_ff >= deadtime_reg_i))
        else $error("low side rose without dead time");

    a_time_base_sel: assert property (@(posedge core_clk_i) disable iff (rst_i)
        pwm_enable_i && !independent_timebase_sel |=> cnt_ff == $past(master_count_i - phase_sh_ff))
        else $error("master count not followed");

    a_local_period: assert property (@(posedge core_clk_i) disable iff (rst_i)
        pwm_enable_i && independent_timebase_sel && pclk_en && loc_last |=> cnt_ff == '0)
        else $error("local period did not wrap");

    a_current_restart: assert property (@(posedge core_clk_i) disable iff (rst_i)
        pwm_enable_i && xrst_mode && independent_timebase_sel && current_reset_i && pclk_en
        |=> cnt_ff == '0 && period_boundary_o)
        else $error("current reset did not restart");

    a_deferred_duty: assert property (@(posedge core_clk_i) disable iff (rst_i)
        pwm_enable_i && !imm_upd && !bnd |=> $stable(duty_ff))
        else $error("duty changed mid-period");

    a_immediate_duty: assert property (@(posedge core_clk_i) disable iff (rst_i)
        imm_upd |=> duty_ff == $past(duty_sel))
        else $error("immediate duty not applied");

    a_duty_source: assert property (@(posedge core_clk_i) disable iff (rst_i)
        imm_upd && duty_master |=> duty_ff == $past(master_duty_i))
        else $error("master duty not selected");

    a_zero_duty_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !is_comp && bnd && duty_sel == '0 && !ovr_en_h_ff ##1 !ovr_en_h_ff && !is_comp |=> !h_ff)
        else $error("glitch after duty went to zero");

    a_push_pull_alt: assert property (@(posedge core_clk_i) disable iff (rst_i)
        is_push && !ovr_en_h_ff && !ovr_en_l_ff |=> !(h_ff && l_ff))
        else $error("push-pull drove both sides");

    a_override_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !is_comp && !ovr_sync && high_override_enable ##1 !is_comp |=> h_ff == $past(high_ovr_data, 2))
        else $error("override level not forced");

    a_override_sync: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ovr_sync && !bnd |=> $stable(ovr_en_h_ff) && $stable(ovr_en_l_ff))
        else $error("override changed off boundary");

    a_override_async: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !ovr_sync |=> ovr_en_l_ff == $past(low_override_enable))
        else $error("override not taken on clock");

endmodule : complementary_pwm_deadtime_generator

// >>> power_stage_model.sv
`timescale 1ns/1ps
// ****************************************
// Switch pair and current comparator
// ****************************************
module power_stage_model (
    input wire logic core_clk_i,
    input wire logic high_i,
    input wire logic low_i,
    input wire logic guard_i,
    input wire logic [15:0] dt_i,
    input wire logic trip_i,
    output logic current_reset_o,
    output logic fault_o
);
    logic was_h = 1'b0;
    logic was_l = 1'b0;
    int off_run = 0;
    wire rise = (high_i && !was_h) || (low_i && !was_l);
    initial
    begin
        current_reset_o = 1'b0;
        fault_o = 1'b0;
    end
    // Single-cycle trips only: 25 ns stays under the width limit from code 1 up
    // Rising-edge sampling sees pins and dead time as the design does
    always @(posedge core_clk_i)
    begin
        current_reset_o <= trip_i;
        fault_o <= guard_i && ((high_i && low_i) || (rise && off_run < int'(dt_i)));
        was_h <= high_i;
        was_l <= low_i;
        off_run <= (high_i || low_i) ? 0 : off_run + 1;
    end
endmodule : power_stage_model

// >>> pwm_gen_consts.svh
`ifndef PWM_GEN_CONSTS_SVH
`define PWM_GEN_CONSTS_SVH

// ****************************************
// Generator control field positions
// ****************************************
`define GEN_IMM_BIT 0
`define GEN_XRST_BIT 1
`define GEN_DUTY_SRC_BIT 8
`define GEN_ITB_BIT 9

// ****************************************
// Output control field positions
// ****************************************
`define OUT_SYNC_BIT 0
`define OUT_DATA_L_BIT 6
`define OUT_DATA_H_BIT 7
`define OUT_EN_L_BIT 8
`define OUT_EN_H_BIT 9
`define OUT_MODE_LSB 10
`define OUT_MODE_MSB 11

// ****************************************
// Divider and reset values
// ****************************************
`define DIV_MAX_CODE 3'h6
`define DIV_CNT_W 7
`define DIV_RST 7'h00
`define PIN_RST 1'b0

`endif

// >>> pwm_gen_pkg.sv
package pwm_gen_pkg;

    // Output mode field codes
    typedef enum logic [1:0] {
        MODE_COMP = 2'h0,
        MODE_PUSH = 2'h1,
        MODE_RED = 2'h2,
        MODE_IND = 2'h3
    } out_mode_e;

    typedef logic [15:0] ctrl_word_t;

endpackage : pwm_gen_pkg

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    import pwm_gen_pkg::*;
    // ****************************************
    // Bench
    // ****************************************
    localparam int MP = 30;
    logic clk, rst_i, en, trip, cur_rst, fault, mbound, hs, ls, pb;
    logic [2:0] div;
    ctrl_word_t gcr, ocr;
    logic [15:0] ph, dt, duty, mduty, mcount;
    logic [31:0] seed;
    int err_total, checks, gcnt, hc, lc, len, h1, l1, d1;
    complementary_pwm_deadtime_generator #(.CNT_W(16)) dut_u (
        .core_clk_i(clk), .rst_i(rst_i), .pwm_enable_i(en), .pwm_clock_divider_i(div),
        .generator_control_reg_i(gcr), .output_control_reg_i(ocr), .phase_period_reg_i(ph),
        .deadtime_reg_i(dt), .local_duty_reg_i(duty), .master_duty_i(mduty), .master_count_i(mcount),
        .master_boundary_i(mbound), .current_reset_i(cur_rst), .high_side_output_o(hs),
        .low_side_output_o(ls), .period_boundary_o(pb)
    );
    power_stage_model stage_u (
        .core_clk_i(clk), .high_i(hs), .low_i(ls), .guard_i(gcnt == 3), .dt_i(dt),
        .trip_i(trip), .current_reset_o(cur_rst), .fault_o(fault)
    );
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hold-off after a mode or override change: pins are still settling
    always @(negedge clk)
    begin
        mcount <= (rst_i || mcount == 16'(MP - 1)) ? 16'h0 : mcount + 16'h1;
        mbound <= !rst_i && mcount == 16'(MP - 1);
        gcnt <= (ocr[11:8] == 4'h0 && en) ? ((gcnt < 3) ? gcnt + 1 : 3) : 0;
        if (fault === 1'b1)
            chk(1'b0, "switch pair overlap or short gap");
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic int pair_sum(input int pp, input int d);
        return pp ? d : 2 * d;
    endfunction : pair_sum
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task results();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    task meas(input int k, input logic [15:0] nd);
        int n;
        n = 0;
        hc = 0;
        lc = 0;
        len = 0;
        while (pb !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        do
        begin
            if (len == k)
                duty = nd;
            @(negedge clk);
            hc += int'(hs);
            lc += int'(ls);
            len++;
        end while (pb !== 1'b1 && len < 3000);
        if (n >= 3000 || len >= 3000)
        begin
            chk(1'b0, "no period boundary");
            results();
        end
    endtask : meas
    task cfg(input ctrl_word_t g, input ctrl_word_t o, input logic [15:0] p, input logic [15:0] d);
        gcr = g;
        ocr = o;
        ph = p;
        duty = d;
        meas(-1, d);
        meas(-1, d);
    endtask : cfg
    initial
    begin
        seed = 32'h35;
        err_total = 0;
        checks = 0;
        gcnt = 0;
        rst_i = 1'b1;
        en = 1'b0;
        trip = 1'b0;
        div = 3'h0;
        gcr = 16'h0;
        ocr = 16'h0;
        ph = 16'h0;
        dt = 16'h0;
        duty = 16'h0;
        mduty = 16'h0;
        mcount = 16'h0;
        mbound = 1'b0;
        repeat (5) @(negedge clk);
        chk(hs === 1'b0 && ls === 1'b0 && pb === 1'b0, "outputs during reset");
        rst_i = 1'b0;
        @(negedge clk);
        en = 1'b1;
        cfg(16'h0200, 16'h0800, 16'h000C, 16'h0005);
        chk(len == 12 && hc == 5 && lc == 5, "own period and redundant pins");
        repeat (4)
        begin
            d1 = int'(rnd() % 32'hA) + 1;
            duty = 16'(d1);
            meas(-1, duty);
            meas(2, 16'(rnd() % 32'hA + 32'h1));
            chk(hc == d1, "deferred duty applied early");
            d1 = int'(duty);
            meas(-1, duty);
            chk(hc == d1, "deferred duty not applied");
        end
        gcr = 16'h0201;
        for (int i = 0; i < 2; i++)
        begin
            duty = i ? 16'h8 : 16'h2;
            meas(-1, duty);
            meas(0, 16'hA - duty);
            chk(hc >= int'(duty) - 1 && hc <= int'(duty) + 1, "immediate duty");
        end
        mduty = 16'h7;
        cfg(16'h0301, 16'h0800, 16'h000C, 16'h0003);
        chk(hc == 7, "master duty source");
        cfg(16'h0000, 16'h0800, 16'h0004, 16'h0005);
        chk(len == MP && hc == 5, "master time base");
        for (int i = 0; i < 3; i++)
        begin
            cfg(16'h0200, (i == 1) ? 16'h0400 : ((i == 2) ? 16'h0C00 : 16'h0800), 16'h000C, 16'h0006);
            h1 = hc;
            l1 = lc;
            d1 = pair_sum(int'(i == 1), 6);
            meas(-1, duty);
            chk(h1 + hc == d1 && l1 + lc == d1 && h1 * l1 == ((i == 1) ? 0 : 36), "output mode");
            meas(2, 16'h0);
            meas(-1, duty);
            chk(hc + lc == 0, "glitch after zero duty");
        end
        cfg(16'h0200, 16'h0800, 16'h0028, 16'h0000);
        for (int e = 1; e < 4; e++)
            for (int v = 0; v < 4; v++)
            begin
                ocr = 16'h0800 | 16'(e << 8) | 16'(v << 6);
                repeat (4) @(negedge clk);
                chk(hs === (e[1] & v[1]) && ls === (e[0] & v[0]), "override level");
            end
        meas(-1, duty);
        ocr = 16'h0800;
        meas(-1, duty);
        ocr = 16'h0BC1;
        repeat (4) @(negedge clk);
        chk(hs === 1'b0 && ls === 1'b0, "synced override early");
        meas(-1, duty);
        chk(hc == 40 && lc == 40, "synced override period");
        repeat (3) @(negedge clk);
        chk(hs === 1'b1 && ls === 1'b1, "synced override late");
        repeat (5)
        begin
            dt = 16'(rnd() % 32'h4 + 32'h3);
            cfg(16'h0200, 16'h0000, 16'h0010, 16'(rnd() % 32'hE + 32'h1));
            chk(len == 16 && hc + lc <= 16 - int'(dt), "dead time in period");
            ocr = 16'h03C0;
            repeat (int'(rnd() % 32'h10) + 1) @(negedge clk);
            ocr = 16'h0000;
            meas(-1, duty);
        end
        dt = 16'h4;
        cfg(16'h0000, 16'h0000, 16'h0004, 16'h000A);
        repeat (7) @(negedge clk);
        ph = 16'h2;
        meas(-1, duty);
        repeat (7) @(negedge clk);
        ph = 16'hE;
        meas(-1, duty);
        meas(-1, duty);
        chk(len == MP && hc + lc <= MP - 4, "phase change dead time");
        div = 3'h1;
        cfg(16'h0202, 16'h0800, 16'h0028, 16'h000A);
        repeat (30) @(negedge clk);
        trip = 1'b1;
        @(negedge clk);
        trip = 1'b0;
        repeat (2) @(negedge clk);
        trip = 1'b1;
        @(negedge clk);
        trip = 1'b0;
        repeat (8) @(negedge clk);
        chk(hs === 1'b1, "current reset restart");
        results();
    end
endmodule : tb
